// file: lcd_ctrl_regs.svh
// constants of the lcd controller: bus address, commands, fields, timing
// assumes nothing; included by the controller only
`ifndef LCD_CTRL_REGS_SVH
`define LCD_CTRL_REGS_SVH
`define SLAVE_ADDR 7'h38
`define CMD_DISPLAY 8'h80
`define CMD_DRIVE 8'h82
`define CMD_SYSTEM 8'h84
`define CMD_FRAME 8'h86
`define CMD_BLINK 8'h88
`define CMD_IVA 8'h8A
`define PTR_MAX_4COM 4'h9
`define PTR_MAX_8COM 4'hF
`define DRV_DUTY_BIT 1
`define DRV_BIAS_BIT 0
`define SYS_OSC_BIT 1
`define SYS_DISP_BIT 0
`define FRM_RATE_BIT 0
`define IVA_DE_BIT 5
`define IVA_VE_BIT 4
`define CORE_HZ 10000000
`define FSYS_HZ 32768
`define FRAME_LO_HZ 80
`define FRAME_HI_HZ 160
`define BLINK_DIV1 16384
`define BLINK_DIV2 32768
`define BLINK_DIV3 65536
`endif

// file: lcd_ctrl_pkg.sv
// types shared by the lcd controller
// assumes nothing; takes no constants from lcd_ctrl_regs.svh
package lcd_ctrl_pkg;
  typedef struct packed {
    logic eight_com;
    logic quarter_bias;
    logic osc_on;
    logic disp_on;
    logic frame_160;
    logic [1:0] blink;
    logic seg_pin;
    logic trim_en;
    logic [3:0] trim;
  } cfg_s;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_SKIP} bus_st_e;
endpackage : lcd_ctrl_pkg

// file: lcd_ctrl.sv
// i2c write slave, 16 byte display ram and common/segment scan logic
// assumes an external open-drain pad resolving sda from o_sda_oe
// Function
// - eight-common: ram 00H-0FH to segments 4-19
// - oscillator stopped until host enables it
// - all lcd timing from internal system clock
// - third bias bypasses centre divider resistor
// - segments from scan phase and stored bit
// - four or eight commons by drive mode
// - address byte loads display pointer
// - blink divides system clock by mode
// - blink blanks all segments together, commons keep scanning
// - frame rate 80 or 160 Hz
// - four bit voltage trim, default full
// - data changes only while clock low
// - detect start and stop conditions
// - repeated start restarts address reception
// - bytes are eight bits, msb first
// - acknowledge low through ninth clock high
// - acknowledge only fixed address 0111000
// - eighth address bit selects read or write
// - command byte then setting byte applies
// - display command, address, data stores byte
// - page write increments pointer, wraps by mode
// - four-common: addresses 00H-09H each drive two segments
// - power-on defaults: 80Hz, 1/4 duty, off
// - undefined commands change nothing
`timescale 1ns/1ps
`include "lcd_ctrl_regs.svh"
module lcd_ctrl #(
  parameter int SYS_DIV = `CORE_HZ / `FSYS_HZ
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [7:0] o_com_sel,
  output logic [19:0] o_seg_on,
  output logic o_frame_inv,
  output logic o_bias_bypass,
  output logic [3:0] o_lcd_voltage_trim_code,
  output logic o_trim_enable,
  output logic o_seg_shared_pin_is_seg,
  output logic o_osc_run
);
  localparam int BIDX1 = $clog2(`BLINK_DIV1) - 1;
  localparam int BIDX2 = $clog2(`BLINK_DIV2) - 1;
  localparam int BIDX3 = $clog2(`BLINK_DIV3) - 1;
  localparam lcd_ctrl_pkg::cfg_s CFG_RST = '{
    eight_com: 1'b0, quarter_bias: 1'b0, osc_on: 1'b0, disp_on: 1'b0,
    frame_160: 1'b0, blink: 2'h0, seg_pin: 1'b1, trim_en: 1'b1,
    trim: 4'h0};

  // system ticks per common phase for the chosen frame rate and duty
  function automatic logic [8:0] phase_len(input logic f160,
                                           input logic eight);
    int hz;
    int n;
    hz = f160 ? `FRAME_HI_HZ : `FRAME_LO_HZ;
    n = eight ? 8 : 4;
    phase_len = 9'(`FSYS_HZ / (hz * n));
  endfunction : phase_len

  function automatic logic [3:0] ptr_max(input logic eight);
    ptr_max = eight ? `PTR_MAX_8COM : `PTR_MAX_4COM;
  endfunction : ptr_max

  // pin synchronisers; stage 2 only delays for edge detection
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda_in};
    end
  end
  logic scl_h;
  logic sda_h;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  assign scl_h = scl_sync_reg[1];
  assign sda_h = sda_sync_reg[1];
  assign scl_rise = scl_h & ~scl_sync_reg[2];
  assign scl_fall = ~scl_h & scl_sync_reg[2];
  assign start = scl_h & scl_sync_reg[2] & ~sda_h & sda_sync_reg[2];
  assign stop = scl_h & scl_sync_reg[2] & sda_h & ~sda_sync_reg[2];

  // bus receiver and configuration
  lcd_ctrl_pkg::bus_st_e bus_st_reg, bus_st_next;
  lcd_ctrl_pkg::cfg_s cfg_reg, cfg_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [1:0] byte_idx_reg, byte_idx_next;
  logic [7:0] cmd_reg, cmd_next;
  logic ack_reg, ack_next;
  logic inc_reg, inc_next;
  logic read_reg, read_next;
  logic [3:0] ptr_reg, ptr_next;
  logic ram_we;
  logic [7:0] ram_reg [16];

  always_comb begin
    bus_st_next = bus_st_reg;
    cfg_next = cfg_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_idx_next = byte_idx_reg;
    cmd_next = cmd_reg;
    ack_next = ack_reg;
    inc_next = inc_reg;
    read_next = read_reg;
    ptr_next = ptr_reg;
    ram_we = 1'b0;
    case (bus_st_reg)
      lcd_ctrl_pkg::BUS_IDLE: begin
      end
      lcd_ctrl_pkg::BUS_RX: begin
        if (scl_rise) begin
          shift_next = {shift_reg[6:0], sda_h};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
          bus_st_next = lcd_ctrl_pkg::BUS_ACK;
          ack_next = 1'b1;
          bit_cnt_next = 4'h0;
          if (byte_idx_reg != 2'h3) begin
            byte_idx_next = byte_idx_reg + 2'h1;
          end
          case (byte_idx_reg)
            2'h0: begin
              if (shift_reg[7:1] != `SLAVE_ADDR) begin
                ack_next = 1'b0;
                bus_st_next = lcd_ctrl_pkg::BUS_SKIP;
              end else begin
                read_next = shift_reg[0];
              end
            end
            2'h1: cmd_next = shift_reg;
            2'h2: begin
              case (cmd_reg)
                `CMD_DISPLAY: ptr_next = shift_reg[3:0];
                `CMD_DRIVE: begin
                  cfg_next.eight_com = shift_reg[`DRV_DUTY_BIT];
                  cfg_next.quarter_bias = shift_reg[`DRV_BIAS_BIT];
                end
                `CMD_SYSTEM: begin
                  cfg_next.osc_on = shift_reg[`SYS_OSC_BIT];
                  cfg_next.disp_on = shift_reg[`SYS_OSC_BIT] &
                                     shift_reg[`SYS_DISP_BIT];
                end
                `CMD_FRAME: cfg_next.frame_160 = shift_reg[`FRM_RATE_BIT];
                `CMD_BLINK: cfg_next.blink = shift_reg[1:0];
                `CMD_IVA: begin
                  cfg_next.seg_pin = shift_reg[`IVA_DE_BIT];
                  cfg_next.trim_en = shift_reg[`IVA_VE_BIT];
                  cfg_next.trim = shift_reg[3:0];
                end
                default: begin
                end
              endcase
            end
            default: begin
              if (cmd_reg == `CMD_DISPLAY) begin
                ram_we = 1'b1;
                inc_next = 1'b1;
              end
            end
          endcase
        end
      end
      lcd_ctrl_pkg::BUS_ACK: begin
        if (scl_fall) begin
          ack_next = 1'b0;
          inc_next = 1'b0;
          if (inc_reg) begin
            // wrap also catches a pointer left high by a mode change
            ptr_next = (ptr_reg >= ptr_max(cfg_reg.eight_com)) ?
                       4'h0 : ptr_reg + 4'h1;
          end
          // reads are acknowledged but sda stays released afterwards
          bus_st_next = read_reg ? lcd_ctrl_pkg::BUS_SKIP :
                                   lcd_ctrl_pkg::BUS_RX;
        end
      end
      lcd_ctrl_pkg::BUS_SKIP: begin
      end
      default: bus_st_next = lcd_ctrl_pkg::BUS_IDLE;
    endcase
    if (start) begin
      bus_st_next = lcd_ctrl_pkg::BUS_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = 2'h0;
      ack_next = 1'b0;
      inc_next = 1'b0;
      read_next = 1'b0;
    end else if (stop) begin
      bus_st_next = lcd_ctrl_pkg::BUS_IDLE;
      ack_next = 1'b0;
      inc_next = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bus_st_reg <= lcd_ctrl_pkg::BUS_IDLE;
      cfg_reg <= CFG_RST;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      cmd_reg <= 8'h00;
      ack_reg <= 1'b0;
      inc_reg <= 1'b0;
      read_reg <= 1'b0;
      ptr_reg <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        ram_reg[i] <= 8'h00;
      end
    end else begin
      bus_st_reg <= bus_st_next;
      cfg_reg <= cfg_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_idx_reg <= byte_idx_next;
      cmd_reg <= cmd_next;
      ack_reg <= ack_next;
      inc_reg <= inc_next;
      read_reg <= read_next;
      ptr_reg <= ptr_next;
      if (ram_we) begin
        ram_reg[ptr_reg] <= shift_reg;
      end
    end
  end

  // system clock emulation and scan timing; held cleared while osc is off
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic [15:0] blink_cnt_reg, blink_cnt_next;
  logic [8:0] ph_cnt_reg, ph_cnt_next;
  logic [2:0] phase_reg, phase_next;
  logic inv_reg, inv_next;
  logic tick;
  logic last_ph;
  assign tick = tick_cnt_reg == 16'(SYS_DIV - 1);
  assign last_ph = cfg_reg.eight_com ? (phase_reg == 3'h7) :
                                      (phase_reg == 3'h3);

  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    blink_cnt_next = blink_cnt_reg;
    ph_cnt_next = ph_cnt_reg;
    phase_next = phase_reg;
    inv_next = inv_reg;
    if (!cfg_reg.osc_on) begin
      tick_cnt_next = 16'h0000;
      blink_cnt_next = 16'h0000;
      ph_cnt_next = 9'h000;
      phase_next = 3'h0;
      inv_next = 1'b0;
    end else begin
      tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (tick) begin
        blink_cnt_next = blink_cnt_reg + 16'h0001;
        ph_cnt_next = ph_cnt_reg + 9'h001;
        if (ph_cnt_reg >= phase_len(cfg_reg.frame_160,
                                    cfg_reg.eight_com) - 9'h001) begin
          ph_cnt_next = 9'h000;
          phase_next = last_ph ? 3'h0 : phase_reg + 3'h1;
          inv_next = inv_reg ^ last_ph;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      tick_cnt_reg <= 16'h0000;
      blink_cnt_reg <= 16'h0000;
      ph_cnt_reg <= 9'h000;
      phase_reg <= 3'h0;
      inv_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      blink_cnt_reg <= blink_cnt_next;
      ph_cnt_reg <= ph_cnt_next;
      phase_reg <= phase_next;
      inv_reg <= inv_next;
    end
  end

  // drive outputs; levels here are on/off, the analog stage adds bias
  logic blank;
  logic [7:0] com_next;
  logic [19:0] seg_next;
  always_comb begin
    case (cfg_reg.blink)
      2'h1: blank = blink_cnt_reg[BIDX1];
      2'h2: blank = blink_cnt_reg[BIDX2];
      2'h3: blank = blink_cnt_reg[BIDX3];
      default: blank = 1'b0;
    endcase
    com_next = 8'h00;
    seg_next = 20'h00000;
    if (cfg_reg.disp_on) begin
      com_next = 8'h01 << phase_reg;
      if (!blank) begin
        for (int a = 0; a < 16; a++) begin
          if (cfg_reg.eight_com) begin
            seg_next[a + 4] = ram_reg[a][phase_reg];
          end else if (a < 10) begin
            seg_next[2 * a] = ram_reg[a][{1'b0, phase_reg[1:0]}];
            seg_next[2 * a + 1] = ram_reg[a][{1'b1, phase_reg[1:0]}];
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_com_sel <= 8'h00;
      o_seg_on <= 20'h00000;
      o_frame_inv <= 1'b0;
      o_bias_bypass <= 1'b1;
      o_lcd_voltage_trim_code <= 4'h0;
      o_trim_enable <= 1'b1;
      o_seg_shared_pin_is_seg <= 1'b1;
      o_osc_run <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_com_sel <= com_next;
      o_seg_on <= seg_next;
      o_frame_inv <= inv_reg;
      o_bias_bypass <= ~cfg_reg.quarter_bias;
      o_lcd_voltage_trim_code <= cfg_reg.trim;
      o_trim_enable <= cfg_reg.trim_en;
      o_seg_shared_pin_is_seg <= cfg_reg.seg_pin;
      o_osc_run <= cfg_reg.osc_on;
      o_sda_out <= 1'b0;
    end
  end
  assign o_sda_oe = ack_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  sequence s_byte_done;
    bus_st_reg == lcd_ctrl_pkg::BUS_RX && scl_fall &&
    bit_cnt_reg == 4'h8 && !start && !stop;
  endsequence
  sequence s_ack_end;
    bus_st_reg == lcd_ctrl_pkg::BUS_ACK && scl_fall && inc_reg &&
    !start && !stop;
  endsequence

  chk_addr_nack: assert property (
    (s_byte_done and (byte_idx_reg == 2'h0 &&
     shift_reg[7:1] != `SLAVE_ADDR)) |=> !o_sda_oe [*3])
    else $error("unmatched address was acknowledged");
  chk_ack_hold: assert property (
    (o_sda_oe && scl_h && !start && !stop) |=> o_sda_oe)
    else $error("acknowledge released during clock high");
  chk_sda_low: assert property (
    $changed(o_sda_oe) |-> !scl_h)
    else $error("sda drive changed while clock high");
  chk_start_restart: assert property (
    start |=> bus_st_reg == lcd_ctrl_pkg::BUS_RX &&
              bit_cnt_reg == 4'h0 && byte_idx_reg == 2'h0)
    else $error("start did not restart address reception");
  chk_stop_idle: assert property (
    (stop && !start) |=> bus_st_reg == lcd_ctrl_pkg::BUS_IDLE && !o_sda_oe)
    else $error("stop did not free the bus");
  chk_ptr_wrap: assert property (
    (s_ack_end and ptr_reg == ptr_max(cfg_reg.eight_com)) |=>
    ptr_reg == 4'h0)
    else $error("pointer did not wrap");
  chk_ptr_step: assert property (
    (s_ack_end and ptr_reg < ptr_max(cfg_reg.eight_com)) |=>
    ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("pointer did not advance");
  chk_osc_stop: assert property (
    !cfg_reg.osc_on |=> tick_cnt_reg == 16'h0000 && o_com_sel == 8'h00)
    else $error("timing ran with oscillator off");
  chk_blank_all: assert property (
    (blank && cfg_reg.blink != 2'h0) |=> o_seg_on == 20'h00000)
    else $error("segments lit during blink blank");
  chk_bias_sel: assert property (
    $changed(cfg_reg.quarter_bias) |=> o_bias_bypass == !cfg_reg.quarter_bias)
    else $error("bias bypass not following bias select");
endmodule : lcd_ctrl

// file: lcd_host_model.sv
// i2c bus master model that drives the lcd controller's bus pins
// assumes a pull-up on sda: the wire is low while any party pulls it
`timescale 1ns/1ps
module lcd_host_model (
  input wire logic i_core_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  localparam int HALF = 8;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #10;
  endtask : wait_cyc
  // sda moves two cycles into the low phase, never while scl is high
  task automatic clock_bit(input logic low, output logic seen);
    wait_cyc(2);
    o_sda_low = low;
    wait_cyc(HALF);
    o_scl = 1'b1;
    wait_cyc(HALF / 2);
    seen = i_sda;
    wait_cyc(HALF / 2);
    o_scl = 1'b0;
  endtask : clock_bit
  // also serves as repeated start when scl is low
  task automatic send_start();
    wait_cyc(2);
    o_sda_low = 1'b0;
    wait_cyc(HALF);
    o_scl = 1'b1;
    wait_cyc(HALF);
    o_sda_low = 1'b1;
    wait_cyc(HALF);
    o_scl = 1'b0;
  endtask : send_start
  task automatic send_stop();
    wait_cyc(2);
    o_sda_low = 1'b1;
    wait_cyc(HALF);
    o_scl = 1'b1;
    wait_cyc(HALF);
    o_sda_low = 1'b0;
    wait_cyc(HALF);
  endtask : send_stop
  // ninth bit released by the master: ack seen, or a nack when reading
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(~b[i], s);
    clock_bit(1'b0, s);
    ack = (s === 1'b0);
  endtask : write_byte
endmodule : lcd_host_model

// file: i2c_lcd_display_controller_test.sv
// self-checking bench of the lcd controller against an integer model
// assumes lcd_host_model as bus master and a pull-up on sda
`timescale 1ns/1ps
module i2c_lcd_display_controller_test;
  localparam int SDIV = 2;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic scl, sda_low, sda, oe, sda_out, inv, bias, trim_en, seg_pin, osc;
  logic [7:0] com;
  logic [19:0] seg;
  logic [3:0] trim;
  logic [7:0] ram_m [16];
  logic [31:0] rng = 32'h0000FB48;
  logic bias_m = 1'b1, eight_m = 1'b0, osc_m = 1'b0, frm_m = 1'b0;
  logic ve_m = 1'b1, de_m = 1'b1;
  logic [3:0] trim_m = 4'h0;
  int ptr_m, num_errors, n_compared, cyc, t;
  assign sda = ((oe === 1'b1) ? sda_out : 1'b1) & ~sda_low;
  lcd_ctrl #(.SYS_DIV(SDIV)) dut_u (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
    .o_com_sel(com), .o_seg_on(seg), .o_frame_inv(inv),
    .o_bias_bypass(bias), .o_lcd_voltage_trim_code(trim),
    .o_trim_enable(trim_en), .o_seg_shared_pin_is_seg(seg_pin),
    .o_osc_run(osc)
  );
  lcd_host_model host_u (
    .i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low)
  );
  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // the longest legal run is the blink period search, well inside this
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] xs8();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : xs8
  task automatic tick();
    @(posedge i_core_clk);
    #10;
  endtask : tick
  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic ack;
    host_u.write_byte(b, ack);
    check("ack", ack, exp_ack);
  endtask : xfer
  task automatic check_cfg();
    check("bias_bypass", bias, bias_m);
    check("trim", trim, trim_m);
    check("trim_en", trim_en, ve_m);
    check("seg_pin", seg_pin, de_m);
    check("osc_run", osc, osc_m);
  endtask : check_cfg
  task automatic cfg(input logic [7:0] cmd, input logic [7:0] v);
    host_u.send_start();
    xfer(8'h70, 1'b1);
    xfer(cmd, 1'b1);
    xfer(v, 1'b1);
    host_u.send_stop();
    case (cmd)
      8'h82: {eight_m, bias_m} = {v[1], ~v[0]};
      8'h84: osc_m = v[1];
      8'h86: frm_m = v[0];
      8'h8A: {de_m, ve_m, trim_m} = v[5:0];
      default: ;
    endcase
    repeat (3) tick();
    check_cfg();
  endtask : cfg
  task automatic pg(input logic [7:0] a, input int n);
    logic [7:0] d;
    host_u.send_start();
    xfer(8'h70, 1'b1);
    xfer(8'h80, 1'b1);
    xfer(a, 1'b1);
    ptr_m = a[3:0];
    repeat (n) begin
      d = xs8();
      xfer(d, 1'b1);
      ram_m[ptr_m] = d;
      ptr_m = (ptr_m >= (eight_m ? 15 : 9)) ? 0 : ptr_m + 1;
    end
    host_u.send_stop();
  endtask : pg
  function automatic logic [19:0] exp_seg(input int ph);
    logic [19:0] s = 20'h0;
    for (int k = 0; k < 16; k++) begin
      if (eight_m) s[k + 4] = ram_m[k][ph];
      else if (k < 10) s[2 * k +: 2] = {ram_m[k][ph + 4], ram_m[k][ph]};
    end
    return s;
  endfunction : exp_seg
  task automatic phase_wait(output int n);
    logic [7:0] p;
    p = com;
    n = 0;
    while (com === p && n < 2000) begin
      tick();
      n++;
    end
  endtask : phase_wait
  task automatic scan_chk(input int nph);
    int ph, n, len, pph;
    logic pinv;
    len = 32768 / ((frm_m ? 160 : 80) * (eight_m ? 8 : 4)) * SDIV;
    phase_wait(n);
    pph = -1;
    pinv = 1'b0;
    repeat (nph) begin
      tick();
      tick();
      ph = 0;
      for (int i = 0; i < 8; i++) if (com[i] === 1'b1) ph = i;
      // the frame polarity flips only when the scan wraps to phase 0
      if (pph >= 0) check("frame_inv", inv, pinv ^ (ph == 0));
      pph = ph;
      pinv = inv;
      check("com_onehot", $onehot(com), 1'b1);
      check("com_count", ph < (eight_m ? 8 : 4), 1'b1);
      check("seg", seg, exp_seg(ph));
      phase_wait(n);
      check("phase_len", n + 2, len);
    end
  endtask : scan_chk
  task automatic seg_wait(input logic blank, output int n);
    n = 0;
    while (((seg === 20'h0) !== blank) && n < 40000) begin
      tick();
      n++;
    end
  endtask : seg_wait
  initial begin
    for (int i = 0; i < 16; i++) ram_m[i] = 8'h00;
    repeat (8) @(posedge i_core_clk);
    #10;
    i_srst = 1'b0;
    repeat (4) tick();
    check_cfg();
    check("com_rst", com, 8'h00);
    check("seg_rst", seg, 20'h0);
    host_u.send_start();
    xfer(8'h72, 1'b0);
    xfer(8'h84, 1'b0);
    xfer(8'h03, 1'b0);
    host_u.send_start();
    xfer(8'h70, 1'b1);
    host_u.send_stop();
    check_cfg();
    cfg(8'h8C, 8'hFF);
    host_u.send_start();
    xfer(8'h71, 1'b1);
    xfer(8'hFF, 1'b0);
    host_u.send_stop();
    cfg(8'h82, 8'h01);
    cfg(8'h82, 8'h00);
    cfg(8'h8A, xs8());
    cfg(8'h86, 8'h00);
    cfg(8'h84, 8'h03);
    pg(8'h08, 12);
    scan_chk(8);
    cfg(8'h86, 8'h01);
    scan_chk(4);
    cfg(8'h82, 8'h02);
    pg(8'h0E, 18);
    scan_chk(8);
    cfg(8'h88, 8'h01);
    seg_wait(1'b1, t);
    seg_wait(1'b0, t);
    seg_wait(1'b1, t);
    check("blink_half", t, 8192 * SDIV);
    check("com_in_blank", com !== 8'h00, 1'b1);
    cfg(8'h88, 8'h00);
    scan_chk(2);
    cfg(8'h84, 8'h00);
    repeat (4) tick();
    check("com_off", com, 8'h00);
    check("seg_off", seg, 20'h0);
    close_out();
  end
endmodule : i2c_lcd_display_controller_test
